//--- shared/mmc_pkg.sv
// Constants, register map, carriers and state type of the memory map and
// mode control unit. Assumes one bus clock domain; nothing here is clocked.
// Notes on behaviour
// - Mode pin sampled as reset releases
// - Pin rules in reset, mode bit after, for the direct page guard; mode output shows the mode bit
// - Sampled pin level loaded into mode bit
// - Mode writes act only on permitted changes
// - Forbidden change ignored, locks bit outside special
// - Secured device ignores all mode writes
// - Special mode enters background debug every reset
// - Unmapped core access requests system reset
// - Arbitrate core and debug, route granted access
// - Each master has its own mapping scheme
// - Paging reaches 256 KByte global space
// - Secured device denies external flash access
// - Odd address flagged misaligned, even aligned
// - Direct page supplies local address bits 15:8
// - Direct page: anytime special, once normal
// - Page index picks 16KB block at 0x8000
// - Page index resets to 0x0E
package mmc_pkg;
  // Register indices; byte address is four times the index
  localparam int unsigned IDX_W      = 8;
  localparam int unsigned ADDR_LSB   = 2;
  localparam logic [7:0] IDX_RSVD_A  = 8'h0a;
  localparam logic [7:0] IDX_MODE    = 8'h0b;
  localparam logic [7:0] IDX_RSVD_10 = 8'h10;
  localparam logic [7:0] IDX_DIRECT  = 8'h11;
  localparam logic [7:0] IDX_RSVD_12 = 8'h12;
  localparam logic [7:0] IDX_RSVD_13 = 8'h13;
  localparam logic [7:0] IDX_RSVD_14 = 8'h14;
  localparam logic [7:0] IDX_PAGE    = 8'h15;
  // Field layout and reset values
  localparam int unsigned MODE_POS   = 7;
  localparam logic        MODE_SS    = 1'b0;
  localparam logic        MODE_NS    = 1'b1;
  localparam logic [7:0]  DP_RESET   = 8'h00;
  localparam logic [3:0]  PAGE_RESET = 4'he;
  // Address widths
  localparam int unsigned LADDR_W = 16;
  localparam int unsigned GADDR_W = 18;
  localparam int unsigned PAGE_W  = 4;
  localparam int unsigned OFFS_W  = 14;
  localparam int unsigned DATA_W  = 16;
  // Local 16KB slots and the fixed pages behind them
  localparam logic [1:0] SLOT_LOW   = 2'b00;
  localparam logic [1:0] SLOT_MID   = 2'b01;
  localparam logic [1:0] SLOT_WIN   = 2'b10;
  localparam logic [3:0] PAGE_FIX_L = 4'hc;
  localparam logic [3:0] PAGE_FIX_M = 4'hd;
  localparam logic [3:0] PAGE_FIX_T = 4'hf;
  // Implemented on-chip resources, local view
  localparam logic [15:0] REG_END   = 16'h0400;
  localparam logic [15:0] RAM_LO    = 16'h3000;
  localparam logic [15:0] RAM_HI    = 16'h4000;
  localparam logic [3:0]  FLASH_MIN = 4'h8;
  // Masters
  localparam int unsigned N_MST = 2;
  localparam int unsigned M_CPU = 0;
  localparam int unsigned M_BDM = 1;

  // Reset capture phase
  typedef enum logic [1:0] {
    MMC_ST_HOLD = 2'b01,
    MMC_ST_RUN  = 2'b10
  } mmc_phase_e;

  // Request from one bus master
  typedef struct packed {
    logic                valid;
    logic                write;
    logic                direct;
    logic                use_dbg_page;
    logic [PAGE_W-1:0]   debug_page_index;
    logic [LADDR_W-1:0]  addr;
    logic [DATA_W-1:0]   wdata;
  } mmc_req_s;

  // Granted access routed to the on-chip resources
  typedef struct packed {
    logic                valid;
    logic                master;
    logic                write;
    logic                misaligned;
    logic                denied;
    logic [GADDR_W-1:0]  gaddr;
    logic [DATA_W-1:0]   wdata;
  } mmc_acc_s;

  // Whole state of the top module
  typedef struct packed {
    mmc_phase_e          phase;
    logic                mode;
    logic                locked;
    logic [7:0]          dp;
    logic                dp_written;
    logic [PAGE_W-1:0]   program_window_page;
    logic                bdm_active;
    logic                rst_req;
    logic [N_MST-1:0]    grant;
    mmc_acc_s            acc;
    logic                wr_pend;
    logic [IDX_W-1:0]    wr_idx;
    logic [31:0]         rdata;
  } mmc_state_s;

  localparam mmc_state_s ST_RESET = '{
    phase: MMC_ST_HOLD,
    dp:    DP_RESET,
    program_window_page: PAGE_RESET,
    default: '0
  };
endpackage

//--- logic/mmc_addr_map.sv
// Local to global translation for one master, with resource checks.
// Purely combinational; the top registers what it needs.
`timescale 1ns/100ps
module mmc_addr_map (
  input  mmc_pkg::mmc_req_s                req,
  input  logic                             is_bdm,
  input  logic                             secured,
  input  logic [7:0]                       dp,
  input  logic [mmc_pkg::PAGE_W-1:0]       win_page,
  output logic [mmc_pkg::GADDR_W-1:0]      gaddr,
  output logic                             unmapped,
  output logic                             denied,
  output logic                             misaligned
);
  logic [mmc_pkg::LADDR_W-1:0] local_a;  // Effective local address
  logic [mmc_pkg::PAGE_W-1:0]  page;     // Page behind the slot
  logic                        in_regs;
  logic                        in_ram;
  logic                        in_flash;

  // Page selection and resource decode
  always_comb begin
    local_a = req.direct ? {dp, req.addr[7:0]} : req.addr;
    case (local_a[15:14])
      mmc_pkg::SLOT_LOW: page = mmc_pkg::PAGE_FIX_L;
      mmc_pkg::SLOT_MID: page = mmc_pkg::PAGE_FIX_M;
      mmc_pkg::SLOT_WIN: page = win_page;
      default:           page = mmc_pkg::PAGE_FIX_T;
    endcase
    // Page plus slot offset spans the full global space
    gaddr    = {page, local_a[mmc_pkg::OFFS_W-1:0]};
    in_regs  = local_a < mmc_pkg::REG_END;
    in_ram   = (local_a >= mmc_pkg::RAM_LO) && (local_a < mmc_pkg::RAM_HI);
    in_flash = !in_regs && !in_ram && (page >= mmc_pkg::FLASH_MIN);
    unmapped   = !(in_regs || in_ram || in_flash);
    // Debug master counts as external access
    denied     = secured && is_bdm && in_flash;
    misaligned = local_a[0];
  end
endmodule

//--- logic/mmc_arbiter.sv
// Fixed priority pick between the two masters; debug wins.
// A master granted last cycle is held off one cycle so a held request
// is not taken twice.
`timescale 1ns/100ps
module mmc_arbiter (
  input  logic [mmc_pkg::N_MST-1:0] req_valid,
  input  logic [mmc_pkg::N_MST-1:0] blocked,
  output logic [mmc_pkg::N_MST-1:0] grant
);
  logic [mmc_pkg::N_MST-1:0] ok;

  // One grant at most per cycle
  always_comb begin
    ok    = req_valid & ~blocked;
    grant = '0;
    if (ok[mmc_pkg::M_BDM]) begin
      grant[mmc_pkg::M_BDM] = 1'b1;
    end else if (ok[mmc_pkg::M_CPU]) begin
      grant[mmc_pkg::M_CPU] = 1'b1;
    end
  end
endmodule

//--- logic/mmc_top.sv
// Memory map and mode control unit: mode capture and write guard,
// direct page and program page registers, master arbitration and
// address routing, plus an AHB-Lite register slave.
// Assumes one 100 MHz bus clock, single word transfers, masters that
// hold a request until they see their grant.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/100ps
module mmc_top (
  input  logic                      hclk,
  input  logic                      hresetn,
  input  logic                      hsel,
  input  logic [31:0]               haddr,
  input  logic [1:0]                htrans,
  input  logic                      hwrite,
  input  logic [2:0]                hsize,
  input  logic                      hready,
  input  logic [31:0]               hwdata,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  logic                      boot_select_input,
  input  logic                      secured,
  input  logic                      bdm_exit,
  input  mmc_pkg::mmc_req_s         cpu_req,
  input  mmc_pkg::mmc_req_s         bdm_req,
  output logic                      cpu_grant,
  output logic                      bdm_grant,
  output mmc_pkg::mmc_acc_s         acc,
  output logic                      sys_reset_req,
  output logic                      background_debug,
  output logic                      normal_single_chip,
  output logic [7:0]                direct_page_bits,
  output logic [mmc_pkg::PAGE_W-1:0] page_index_bits
);
  mmc_pkg::mmc_state_s st_reg;   // All state of the unit
  mmc_pkg::mmc_state_s st_next;  // Its next value

  // Requests of both masters, indexed by master number
  mmc_pkg::mmc_req_s              reqs       [mmc_pkg::N_MST];
  logic [mmc_pkg::GADDR_W-1:0]    gaddr_m    [mmc_pkg::N_MST];
  logic [mmc_pkg::N_MST-1:0]      unmapped_m;
  logic [mmc_pkg::N_MST-1:0]      denied_m;
  logic [mmc_pkg::N_MST-1:0]      misal_m;
  logic [mmc_pkg::N_MST-1:0]      req_valid;
  logic [mmc_pkg::N_MST-1:0]      grant_now;

  // Bus address phase decode
  logic                           ahb_take;  // Transfer accepted
  logic [mmc_pkg::IDX_W-1:0]      a_idx;     // Register index
  logic                           a_hit;     // Inside the register block
  logic                           mode_eff;  // Mode in force now
  logic                           mode_wr;   // Mode write in data phase
  logic                           dp_wr;     // Direct write in data phase
  logic                           want_mode; // Requested mode bit

  assign reqs[mmc_pkg::M_CPU] = cpu_req;
  assign reqs[mmc_pkg::M_BDM] = bdm_req;
  assign ahb_take = hsel && hready && htrans[1];
  assign a_idx    = haddr[mmc_pkg::IDX_W+mmc_pkg::ADDR_LSB-1:
                          mmc_pkg::ADDR_LSB];
  assign a_hit    = (haddr[31:mmc_pkg::IDX_W+mmc_pkg::ADDR_LSB] == '0) &&
                    (haddr[mmc_pkg::ADDR_LSB-1:0] == '0);
  assign mode_wr  = st_reg.wr_pend && (st_reg.wr_idx == mmc_pkg::IDX_MODE);
  assign dp_wr    = st_reg.wr_pend && (st_reg.wr_idx == mmc_pkg::IDX_DIRECT);
  assign want_mode = hwdata[mmc_pkg::MODE_POS];

  // Until the pin is captured the pin itself sets the mode
  assign mode_eff = (st_reg.phase == mmc_pkg::MMC_ST_HOLD) ?
                    boot_select_input : st_reg.mode;

  // Register read value; unimplemented bits and reserved words are zero
  function automatic logic [31:0] reg_read(
    input logic [mmc_pkg::IDX_W-1:0] idx,
    input mmc_pkg::mmc_state_s       s
  );
    logic [31:0] v;
    v = '0;
    case (idx)
      mmc_pkg::IDX_MODE:   v[mmc_pkg::MODE_POS] = s.mode;
      mmc_pkg::IDX_DIRECT: v[7:0] = s.dp;
      mmc_pkg::IDX_PAGE:   v[mmc_pkg::PAGE_W-1:0] = s.program_window_page;
      default:             v = '0;
    endcase
    return v;
  endfunction

  // One translator per master; each carries its own scheme
  generate
    for (genvar g = 0; g < mmc_pkg::N_MST; g++) begin : g_map
      logic [mmc_pkg::PAGE_W-1:0] win_page;
      // Debug master may use its own page index
      assign win_page = (g == mmc_pkg::M_BDM && reqs[g].use_dbg_page) ?
                        reqs[g].debug_page_index : st_reg.program_window_page;
      assign req_valid[g] = reqs[g].valid;
      mmc_addr_map u_map (
        .req        (reqs[g]),
        .is_bdm     (g == mmc_pkg::M_BDM),
        .secured    (secured),
        .dp         (st_reg.dp),
        .win_page   (win_page),
        .gaddr      (gaddr_m[g]),
        .unmapped   (unmapped_m[g]),
        .denied     (denied_m[g]),
        .misaligned (misal_m[g])
      );
    end
  endgenerate

  // Arbiter; last cycle's winner sits out one cycle
  mmc_arbiter u_arb (
    .req_valid (req_valid),
    .blocked   (st_reg.grant),
    .grant     (grant_now)
  );

  // Next state of the whole unit
  always_comb begin
    st_next         = st_reg;
    st_next.rst_req = 1'b0;
    st_next.grant   = grant_now;
    st_next.acc     = '0;

    // Debug firmware leaves the active state; placed ahead of the capture
    // so that a capture in the same cycle wins
    if (bdm_exit) begin
      st_next.bdm_active = 1'b0;
    end

    // Capture phase: first edge after reset release
    case (st_reg.phase)
      mmc_pkg::MMC_ST_HOLD: begin
        st_next.mode  = boot_select_input;
        st_next.phase = mmc_pkg::MMC_ST_RUN;
        // Special mode always starts under debug control
        st_next.bdm_active = (boot_select_input == mmc_pkg::MODE_SS);
      end
      mmc_pkg::MMC_ST_RUN: begin
        st_next.phase = mmc_pkg::MMC_ST_RUN;
      end
      default: begin
        // Illegal code: fall back to recapture
        st_next.phase = mmc_pkg::MMC_ST_HOLD;
      end
    endcase

    // Bus address phase: note writes, fetch read data
    st_next.wr_pend = 1'b0;
    if (ahb_take) begin
      st_next.wr_pend = hwrite && a_hit;
      st_next.wr_idx  = a_idx;
      st_next.rdata   = (!hwrite && a_hit) ? reg_read(a_idx, st_reg) : '0;
    end

    // Mode write; secured device ignores it outright
    if (mode_wr && !secured) begin
      if (!st_reg.locked && want_mode != st_reg.mode) begin
        if (st_reg.mode == mmc_pkg::MODE_SS) begin
          st_next.mode = mmc_pkg::MODE_NS;
        end else begin
          // Refused change; the lock only bites outside special mode
          st_next.locked = 1'b1;
        end
      end
    end

    // Direct page: free in special mode, write once in normal mode
    if (dp_wr) begin
      if (mode_eff == mmc_pkg::MODE_SS || !st_reg.dp_written) begin
        st_next.dp         = hwdata[7:0];
        // Only a write in normal mode uses up the single chance
        st_next.dp_written = st_reg.dp_written ||
                             (mode_eff == mmc_pkg::MODE_NS);
      end
    end

    // Program page index writable at any time
    if (st_reg.wr_pend && st_reg.wr_idx == mmc_pkg::IDX_PAGE) begin
      st_next.program_window_page = hwdata[mmc_pkg::PAGE_W-1:0];
    end

    // Route the granted request
    for (int m = 0; m < mmc_pkg::N_MST; m++) begin
      if (grant_now[m]) begin
        st_next.acc.valid      = 1'b1;
        st_next.acc.master     = (m == mmc_pkg::M_BDM);
        st_next.acc.write      = reqs[m].write;
        st_next.acc.misaligned = misal_m[m];
        st_next.acc.denied     = denied_m[m];
        st_next.acc.gaddr      = gaddr_m[m];
        st_next.acc.wdata      = reqs[m].wdata;
      end
    end

    // Both modes are single chip, so a stray core access always resets
    if (grant_now[mmc_pkg::M_CPU] && unmapped_m[mmc_pkg::M_CPU]) begin
      st_next.rst_req = 1'b1;
    end
  end

  // State register; reset value holds page 0x0E
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= mmc_pkg::ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register, except hreadyout and hresp, which are tied off
  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;
  assign hrdata             = st_reg.rdata;
  assign cpu_grant          = st_reg.grant[mmc_pkg::M_CPU];
  assign bdm_grant          = st_reg.grant[mmc_pkg::M_BDM];
  assign acc                = st_reg.acc;
  assign sys_reset_req      = st_reg.rst_req;
  assign background_debug   = st_reg.bdm_active;
  assign normal_single_chip = st_reg.mode;
  assign direct_page_bits   = st_reg.dp;
  assign page_index_bits    = st_reg.program_window_page;

  // Checks on mode control, registers and routing
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_pin_capture: assert property (
    hresetn && st_reg.phase == mmc_pkg::MMC_ST_HOLD |=>
      st_reg.mode == $past(boot_select_input) &&
      st_reg.phase == mmc_pkg::MMC_ST_RUN)
    else $error("mode pin not captured at reset release");

  a_mode_held: assert property (
    st_reg.phase == mmc_pkg::MMC_ST_RUN && !mode_wr |=>
      $stable(st_reg.mode))
    else $error("mode bit moved without a write");

  a_secure_ignore: assert property (
    mode_wr && secured |=> $stable(st_reg.mode) && $stable(st_reg.locked))
    else $error("mode write acted while secured");

  a_ss_to_ns: assert property (
    mode_wr && !secured && !st_reg.locked &&
    st_reg.mode == mmc_pkg::MODE_SS && want_mode == mmc_pkg::MODE_NS |=>
      st_reg.mode == mmc_pkg::MODE_NS)
    else $error("special to normal change refused");

  a_forbid_lock: assert property (
    mode_wr && !secured && st_reg.mode == mmc_pkg::MODE_NS &&
    want_mode == mmc_pkg::MODE_SS |=>
      st_reg.mode == mmc_pkg::MODE_NS && st_reg.locked)
    else $error("forbidden change not refused and locked");

  a_lock_holds: assert property (
    st_reg.locked |=> st_reg.locked && $stable(st_reg.mode) [*2])
    else $error("locked mode bit changed");

  a_debug_entry: assert property (
    hresetn && st_reg.phase == mmc_pkg::MMC_ST_HOLD &&
    boot_select_input == mmc_pkg::MODE_SS |=> st_reg.bdm_active)
    else $error("special mode did not enter debug");

  a_dp_once: assert property (
    dp_wr && st_reg.mode == mmc_pkg::MODE_NS && st_reg.dp_written &&
    st_reg.phase == mmc_pkg::MMC_ST_RUN |=> $stable(st_reg.dp))
    else $error("direct page written twice in normal mode");

  a_unmapped_rst: assert property (
    grant_now[mmc_pkg::M_CPU] && unmapped_m[mmc_pkg::M_CPU] |=>
      sys_reset_req ##1 !sys_reset_req || cpu_grant)
    else $error("unmapped core access gave no reset pulse");

  a_window_page: assert property (
    grant_now[mmc_pkg::M_CPU] && !cpu_req.direct &&
    cpu_req.addr[15:14] == mmc_pkg::SLOT_WIN |=>
      acc.gaddr[mmc_pkg::GADDR_W-1:mmc_pkg::OFFS_W] == $past(st_reg.program_window_page))
    else $error("window access used wrong page");

  a_reserved_zero: assert property (
    ahb_take && !hwrite && a_idx == mmc_pkg::IDX_RSVD_A |=> hrdata == '0)
    else $error("reserved location read nonzero");

  a_misaligned: assert property (
    grant_now[mmc_pkg::M_CPU] && !cpu_req.direct |=>
      acc.misaligned == $past(cpu_req.addr[0]))
    else $error("alignment flag wrong");

  c_special_boot: cover property (
    st_reg.phase == mmc_pkg::MMC_ST_HOLD &&
    boot_select_input == mmc_pkg::MODE_SS);
  c_leave_special: cover property (
    st_reg.mode == mmc_pkg::MODE_SS ##1 st_reg.mode == mmc_pkg::MODE_NS);
  c_unmapped_reset: cover property (sys_reset_req);
  c_both_request: cover property (
    cpu_req.valid && bdm_req.valid ##1 bdm_grant ##1 cpu_grant);
endmodule

//--- tb/mmc_master_model.sv
// Bus master stand-in for the core or the debug unit on the request port.
// Assumes the unit answers a held request with a one-cycle grant.
`timescale 1ns/100ps
module mmc_master_model (
  input  logic               hclk,
  input  logic               hresetn,
  input  logic               go,
  input  mmc_pkg::mmc_req_s  cmd,
  input  logic               grant,
  input  mmc_pkg::mmc_acc_s  acc,
  output mmc_pkg::mmc_req_s  req,
  output logic               busy,
  output mmc_pkg::mmc_acc_s  seen
);
  // Request held until grant; released lines flip so stale data never
  // passes for a fresh request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req  <= '0;
      busy <= 1'b0;
      seen <= '0;
    end else if (go) begin
      req  <= cmd;
      busy <= 1'b1;
    end else if (busy && grant) begin
      // Grant and routed access arrive together
      req.valid <= 1'b0;
      req.addr  <= ~req.addr;
      req.wdata <= ~req.wdata;
      busy      <= 1'b0;
      seen      <= acc;
    end
  end
endmodule

//--- tb/tb_mmc_top.sv
// Self-checking bench of the memory map and mode control unit.
// Assumes zero wait AHB slave and the two master models on the request side.
`timescale 1ns/100ps
module tb_mmc_top;
  logic              hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]       haddr, hwdata, hrdata, rd;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic              boot_select_input, secured, cpu_grant, bdm_grant;
  logic              sys_reset_req, background_debug, normal_single_chip;
  logic [7:0]        direct_page_bits;
  logic [3:0]        page_index_bits;
  logic              cpu_go, bdm_go, cpu_busy, bdm_busy, bdm_exit;
  mmc_pkg::mmc_req_s cpu_req, bdm_req, cpu_cmd, bdm_cmd;
  mmc_pkg::mmc_acc_s acc, cpu_seen, bdm_seen;
  int                err_count, checks_done, rst_cnt;

  assign hready = hreadyout;

  mmc_top mmc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .boot_select_input(boot_select_input),
    .secured(secured), .bdm_exit(bdm_exit), .cpu_req(cpu_req),
    .bdm_req(bdm_req), .cpu_grant(cpu_grant), .bdm_grant(bdm_grant),
    .acc(acc), .sys_reset_req(sys_reset_req),
    .background_debug(background_debug),
    .normal_single_chip(normal_single_chip),
    .direct_page_bits(direct_page_bits), .page_index_bits(page_index_bits));

  mmc_master_model cpu_m (.hclk(hclk), .hresetn(hresetn), .go(cpu_go),
    .cmd(cpu_cmd), .grant(cpu_grant), .acc(acc), .req(cpu_req),
    .busy(cpu_busy), .seen(cpu_seen));
  mmc_master_model bdm_m (.hclk(hclk), .hresetn(hresetn), .go(bdm_go),
    .cmd(bdm_cmd), .grant(bdm_grant), .acc(acc), .req(bdm_req),
    .busy(bdm_busy), .seen(bdm_seen));

  // Clock, 10 ns period
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Counts system reset pulses; a pulse stands one cycle
  always @(posedge hclk) begin
    if (sys_reset_req === 1'b1) begin
      rst_cnt++;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Mismatches %0d, checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Reset for 20 cycles; the pin stays put across the release edge
  task automatic do_reset(input logic pin, input logic sec);
    hresetn <= 1'b0;
    boot_select_input <= pin;
    secured <= sec;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask

  // One AHB single transfer; the master waits on hready in each phase
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= a;
    do begin @(posedge hclk); end while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge hclk); end while (hready !== 1'b1);
    r = hrdata;
  endtask

  // Write, then read back and compare
  task automatic wr_rd(input logic [31:0] a, input logic [31:0] wd,
                       input logic [31:0] exp);
    ahb(1'b1, a, wd, rd);
    ahb(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask

  // Launch requests on the chosen masters, wait till both go quiet
  task automatic mst(input logic c, input logic b, input logic [15:0] a,
                     input logic dir);
    mmc_pkg::mmc_req_s q;
    q = '0;
    q.valid = 1'b1;
    q.direct = dir;
    q.addr = a;
    @(posedge hclk);
    cpu_cmd <= q;
    bdm_cmd <= q;
    cpu_go <= c;
    bdm_go <= b;
    @(posedge hclk);
    cpu_go <= 1'b0;
    bdm_go <= 1'b0;
    do begin @(posedge hclk); #1; end while (cpu_busy | bdm_busy);
  endtask

  task automatic t_reset_vals();
    do_reset(1'b0, 1'b0);
    chk(32'(normal_single_chip), 32'h0000_0000);
    chk(32'(background_debug), 32'h0000_0001);
    chk(32'(page_index_bits), 32'h0000_000e);
    ahb(1'b0, 32'h0000_002c, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    chk(32'(hresp), 32'h0000_0000);
    // Debug firmware leaves the active state with a one-cycle pulse
    bdm_exit <= 1'b1;
    @(posedge hclk);
    bdm_exit <= 1'b0;
    @(posedge hclk);
    chk(32'(background_debug), 32'h0000_0000);
  endtask

  task automatic t_regs();
    wr_rd(32'h0000_0028, 32'hffff_ffff, 32'h0000_0000);
    wr_rd(32'h0000_0050, 32'hffff_ffff, 32'h0000_0000);
    wr_rd(32'h0000_003c, 32'hffff_ffff, 32'h0000_0000);
    wr_rd(32'h0000_0054, 32'h0000_00ff, 32'h0000_000f);
    wr_rd(32'h0000_0054, 32'h0000_0009, 32'h0000_0009);
    wr_rd(32'h0000_0044, 32'h0000_0012, 32'h0000_0012);
    wr_rd(32'h0000_0044, 32'h0000_0031, 32'h0000_0031);
    chk(32'(direct_page_bits), 32'h0000_0031);
  endtask

  // Page 9 and direct page 0x31 stand from the register scenario
  task automatic t_map();
    mst(1'b1, 1'b0, 16'h8123, 1'b0);
    chk(32'(cpu_seen.gaddr), 32'h0002_4123);
    chk(32'(cpu_seen.valid), 32'h0000_0001);
    mst(1'b1, 1'b0, 16'h0043, 1'b1);
    chk(32'(cpu_seen.gaddr), 32'h0003_3143);
    chk(32'(cpu_seen.misaligned), 32'h0000_0001);
    mst(1'b1, 1'b0, 16'hc002, 1'b0);
    chk(32'(cpu_seen.gaddr), 32'h0003_c002);
    chk(32'(cpu_seen.misaligned), 32'h0000_0000);
    mst(1'b0, 1'b1, 16'h4010, 1'b0);
    chk(32'(bdm_seen.gaddr), 32'h0003_4010);
    chk(32'(bdm_seen.master), 32'h0000_0001);
  endtask

  // Both masters at once: debug first, then the core, each served once
  task automatic t_arb();
    mst(1'b1, 1'b1, 16'h3002, 1'b0);
    chk(32'(bdm_seen.master), 32'h0000_0001);
    chk(32'(cpu_seen.master), 32'h0000_0000);
    chk(32'(cpu_seen.gaddr), 32'h0003_3002);
  endtask

  // Page 3 lies below flash, so the window becomes a hole; it resets
  // only when the core touches it
  task automatic t_unmapped();
    ahb(1'b1, 32'h0000_0054, 32'h0000_0003, rd);
    rst_cnt = 0;
    mst(1'b0, 1'b1, 16'h8000, 1'b0);
    chk(32'(rst_cnt), 32'h0000_0000);
    mst(1'b1, 1'b0, 16'h8000, 1'b0);
    chk(32'(rst_cnt), 32'h0000_0001);
  endtask

  task automatic t_mode();
    wr_rd(32'h0000_002c, 32'h0000_0080, 32'h0000_0080);
    chk(32'(normal_single_chip), 32'h0000_0001);
    wr_rd(32'h0000_002c, 32'h0000_0000, 32'h0000_0080);
    wr_rd(32'h0000_0044, 32'h0000_0055, 32'h0000_0055);
    wr_rd(32'h0000_0044, 32'h0000_0066, 32'h0000_0055);
  endtask

  task automatic t_secure();
    do_reset(1'b0, 1'b1);
    wr_rd(32'h0000_002c, 32'h0000_0080, 32'h0000_0000);
    mst(1'b0, 1'b1, 16'h8000, 1'b0);
    chk(32'(bdm_seen.denied), 32'h0000_0001);
    mst(1'b1, 1'b0, 16'h8000, 1'b0);
    chk(32'(cpu_seen.denied), 32'h0000_0000);
  endtask

  task automatic t_normal_boot();
    do_reset(1'b1, 1'b0);
    chk(32'(normal_single_chip), 32'h0000_0001);
    chk(32'(background_debug), 32'h0000_0000);
    ahb(1'b0, 32'h0000_002c, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0080);
  endtask

  // Main sequence; every input has a value at time zero
  initial begin
    err_count = 0;
    checks_done = 0;
    rst_cnt = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'b00;
    hsize = 3'b010;
    boot_select_input = 1'b0;
    secured = 1'b0;
    cpu_go = 1'b0;
    bdm_go = 1'b0;
    bdm_exit = 1'b0;
    cpu_cmd = '0;
    bdm_cmd = '0;
    t_reset_vals();
    t_regs();
    t_map();
    t_arb();
    t_unmapped();
    t_mode();
    t_secure();
    t_normal_boot();
    complete_run();
  end

  // Hang guard, well beyond the few hundred cycles the run needs
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
endmodule
